// ===== logic/mct_pkg.sv
// Constants, types and helpers shared by the microcore tail instruction block.
// Assumes a 16-bit instruction word and 32-bit APB data.
package mct_pkg;

    // Register byte offsets on APB
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IMM = 8'h08;
    localparam logic [7:0] OFS_BKD_ADDR = 8'h0c;
    localparam logic [7:0] OFS_BKD_DATA = 8'h10;
    localparam logic [7:0] OFS_ALU_BASE = 8'h20;
    localparam logic [7:0] OFS_DEST_BASE = 8'h40;
    localparam int ALU_COUNT = 8;
    localparam int ROW_COUNT = 5;

    // Status register field positions
    localparam int STS_CS = 0;
    localparam int STS_ZERO = 1;
    localparam int STS_ONES = 2;
    localparam int STS_WAIT = 3;
    localparam int STS_BKD = 4;
    localparam int STS_PC = 16;

    // Reset values
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic FLAG_RESET = 1'b0;

    // Instruction patterns and the fixed bits each one compares
    localparam logic [15:0] PAT_TO_INT = 16'h3720;
    localparam logic [15:0] MSK_TO_INT = 16'hfff0;
    localparam logic [15:0] PAT_TO_TWOS = 16'h3730;
    localparam logic [15:0] MSK_TO_TWOS = 16'hfff8;
    localparam logic [15:0] PAT_WAIT = 16'h3500;
    localparam logic [15:0] MSK_WAIT = 16'hffe0;
    localparam logic [15:0] PAT_BKD_WR = 16'h3541;
    localparam logic [15:0] MSK_BKD_WR = 16'hffff;
    localparam logic [15:0] PAT_XOR = 16'h2ed0;
    localparam logic [15:0] MSK_XOR = 16'hfff8;

    // Variable field positions
    localparam int FLD_SIGN_SEL = 3;
    localparam int FLD_REG_HI = 2;
    localparam int FLD_MASK_HI = 4;

    // Core sequencing states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_BKD = 3'b100
    } mct_state_t;

    // True when the fixed opcode bits of an instruction match a pattern
    function automatic logic is_op(input logic [15:0] instr, input logic [15:0] pat,
                                   input logic [15:0] msk);
        is_op = ((instr & msk) == pat);
    endfunction

    // Two's complement over the low fifteen bits
    function automatic logic [14:0] twos15(input logic [14:0] v);
        twos15 = 15'(~v + 15'h0001);
    endfunction

endpackage

// ===== logic/mct_alu_exec.sv
// Combinational execution of the conversion and XOR-mask instructions.
// Assumes the caller presents the selected operand and keeps only legal words here.
`timescale 1ns/100ps
`default_nettype none
module mct_alu_exec
    import mct_pkg::*;
(
    input wire logic [15:0] instr,
    input wire logic [15:0] operand,
    input wire logic [15:0] immediate_mask_register,
    input wire logic cs,
    output logic [15:0] result,
    output logic reg_we,
    output logic next_cs,
    output logic flags_we,
    output logic mask_all_zero_flag,
    output logic mask_all_one_flag
);
    // One instruction at a time; outputs are don't-care unless reg_we is set
    always_comb
    begin
        result = operand;
        reg_we = 1'b0;
        next_cs = cs;
        flags_we = 1'b0;
        mask_all_zero_flag = 1'b0;
        mask_all_one_flag = 1'b0;
        if (is_op(instr, PAT_TO_INT, MSK_TO_INT))
        begin
            reg_we = 1'b1;
            if (operand[15])
            begin
                result = {1'b0, twos15(operand[14:0])};
            end
            else
            begin
                result = operand;
            end
            // Selector 1 replaces the sign, 0 accumulates it by XOR
            if (instr[FLD_SIGN_SEL])
            begin
                next_cs = operand[15];
            end
            else
            begin
                next_cs = cs ^ operand[15];
            end
        end
        else if (is_op(instr, PAT_TO_TWOS, MSK_TO_TWOS))
        begin
            reg_we = 1'b1;
            if (cs)
            begin
                result = {1'b1, twos15(operand[14:0])};
            end
            else
            begin
                result = {1'b0, operand[14:0]};
            end
        end
        else if (is_op(instr, PAT_XOR, MSK_XOR))
        begin
            reg_we = 1'b1;
            flags_we = 1'b1;
            result = operand ^ immediate_mask_register;
            mask_all_zero_flag = (result == 16'h0000);
            mask_all_one_flag = (result == 16'hffff);
        end
    end
endmodule
`default_nettype wire

// ===== logic/mct_tail_core.sv
// Microcore tail instructions: conversion, wait, backdoor write and XOR mask,
// issued by writing instruction words over APB.
// Assumes APB3 signalling on SYS_CLK and wait conditions synchronous to it.
// Assumes the far side takes BKD_WR as a one-cycle write strobe.
`timescale 1ns/100ps
`default_nettype none
module mct_tail_core
    import mct_pkg::*;
#(
    parameter int PC_W = 10,
    parameter int BKD_AW = 16
)
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [ROW_COUNT-1:0] WAIT_COND,
    output logic [PC_W-1:0] CORE_PROGRAM_COUNTER,
    output logic CORE_STALL,
    output logic BKD_WR,
    output logic [BKD_AW-1:0] BKD_ADDR,
    output logic [15:0] BKD_DATA
);
    // Whole module state in one record
    // One record keeps reset and next-state handling in one place
    typedef struct packed {
        mct_state_t state;
        logic [PC_W-1:0] pc;
        logic [ALU_COUNT-1:0][15:0] alu;
        logic [ROW_COUNT-1:0][PC_W-1:0] dest;
        logic [ROW_COUNT-1:0] mask;
        logic [15:0] imm;
        logic [15:0] instr;
        logic [BKD_AW-1:0] bkd_addr;
        logic [15:0] bkd_data;
        logic cs;
        logic zero_flag;
        logic ones_flag;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic bkd_wr;
        logic [BKD_AW-1:0] bkd_addr_o;
        logic [15:0] bkd_data_o;
        logic stall;
    } mct_core_t;

    mct_core_t r;
    mct_core_t next_r;

    logic [15:0] exec_result;
    logic exec_reg_we;
    logic exec_cs;
    logic exec_flags_we;
    logic exec_zero;
    logic exec_ones;
    logic [15:0] issue_word;
    logic [2:0] issue_reg;

    // Legal words are the five instruction shapes this block executes
    function automatic logic is_legal(input logic [15:0] w);
        is_legal = is_op(w, PAT_TO_INT, MSK_TO_INT) | is_op(w, PAT_TO_TWOS, MSK_TO_TWOS)
                 | is_op(w, PAT_WAIT, MSK_WAIT) | is_op(w, PAT_BKD_WR, MSK_BKD_WR)
                 | is_op(w, PAT_XOR, MSK_XOR);
    endfunction

    // Word index of an APB byte address
    // Low address bits are dropped, so byte offsets inside a table word alias it
    function automatic logic [5:0] word_idx(input logic [7:0] a);
        word_idx = a[7:2];
    endfunction

    // Decoded register targets
    function automatic logic is_alu(input logic [7:0] a);
        is_alu = (word_idx(a) >= word_idx(OFS_ALU_BASE))
               && (word_idx(a) < word_idx(OFS_ALU_BASE) + 6'(ALU_COUNT));
    endfunction

    function automatic logic is_dest(input logic [7:0] a);
        is_dest = (word_idx(a) >= word_idx(OFS_DEST_BASE))
                && (word_idx(a) < word_idx(OFS_DEST_BASE) + 6'(ROW_COUNT));
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == OFS_INSTR) || (a == OFS_STATUS) || (a == OFS_IMM)
                  || (a == OFS_BKD_ADDR) || (a == OFS_BKD_DATA) || is_alu(a) || is_dest(a);
    endfunction

    // The instruction under execution is the one written in this access phase
    // Operands come from the register file as it stands before the edge,
    // so a result is never read back in the cycle that writes it
    assign issue_word = PWDATA[15:0];
    assign issue_reg = issue_word[FLD_REG_HI:0];

    // Arithmetic decode lives in its own module; only its result is steered here
    mct_alu_exec u_exec (
        .instr(issue_word),
        .operand(r.alu[issue_reg]),
        .immediate_mask_register(r.imm),
        .cs(r.cs),
        .result(exec_result),
        .reg_we(exec_reg_we),
        .next_cs(exec_cs),
        .flags_we(exec_flags_we),
        .mask_all_zero_flag(exec_zero),
        .mask_all_one_flag(exec_ones)
    );

    // Next-state logic for bus slave, sequencer and register file
    // Defaults come first so every field has a value on every path
    always_comb
    begin
        logic [ROW_COUNT-1:0] fired;
        logic apb_wr;
        logic [2:0] ai;
        logic [2:0] di;
        fired = '0;
        apb_wr = 1'b0;
        ai = 3'h0;
        di = 3'h0;
        next_r = r;
        next_r.bkd_wr = 1'b0;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        ai = 3'(word_idx(PADDR) - word_idx(OFS_ALU_BASE));
        di = 3'(word_idx(PADDR) - word_idx(OFS_DEST_BASE));

        // Setup phase: answer is prepared so the access phase ends at once
        if (PSEL && !PENABLE)
        begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            // Instruction writes are refused while one is still running,
            // so the core stays single-issue and a bad word never half-executes
            if (!is_mapped(PADDR)
                || (PWRITE && PADDR == OFS_INSTR
                    && (r.state != ST_IDLE || !is_legal(PWDATA[15:0]))))
            begin
                next_r.pslverr = 1'b1;
            end
            else if (!PWRITE)
            begin
                if (PADDR == OFS_INSTR)
                    next_r.prdata = {16'h0000, r.instr};
                else if (PADDR == OFS_STATUS)
                begin
                    next_r.prdata[STS_CS] = r.cs;
                    next_r.prdata[STS_ZERO] = r.zero_flag;
                    next_r.prdata[STS_ONES] = r.ones_flag;
                    next_r.prdata[STS_WAIT] = (r.state == ST_WAIT);
                    next_r.prdata[STS_BKD] = (r.state == ST_BKD);
                    next_r.prdata[STS_PC +: PC_W] = r.pc;
                end
                else if (PADDR == OFS_IMM)
                    next_r.prdata = {16'h0000, r.imm};
                else if (PADDR == OFS_BKD_ADDR)
                    next_r.prdata[BKD_AW-1:0] = r.bkd_addr;
                else if (PADDR == OFS_BKD_DATA)
                    next_r.prdata = {16'h0000, r.bkd_data};
                else if (is_alu(PADDR))
                    next_r.prdata = {16'h0000, r.alu[ai]};
                else
                    next_r.prdata[PC_W-1:0] = r.dest[di];
            end
        end

        // Access phase: writes take effect only at the completing edge
        apb_wr = PSEL && PENABLE && r.pready && PWRITE && !r.pslverr;

        // Sequencer for multi-cycle instructions
        // Bus writes further down come later and so win over it
        unique case (r.state)
            ST_IDLE:
            begin
                // Nothing pending; instructions arrive through the bus
            end
            ST_WAIT:
            begin
                // Counter is held here; lowest numbered firing row wins
                // Scanning downwards leaves the lowest row as the last assignment
                fired = r.mask & WAIT_COND;
                for (int k = ROW_COUNT - 1; k >= 0; k--)
                begin
                    if (fired[k])
                        next_r.pc = r.dest[k];
                end
                if (fired != '0)
                    next_r.state = ST_IDLE;
            end
            ST_BKD:
            begin
                // Second cycle samples the live registers, but no bus write can land
                // before that sample, so the value at issue is the one delivered
                // A bus write lands one edge after that sample at the earliest
                next_r.bkd_wr = 1'b1;
                next_r.bkd_addr_o = r.bkd_addr;
                next_r.bkd_data_o = r.bkd_data;
                next_r.pc = PC_W'(r.pc + 1'b1);
                next_r.state = ST_IDLE;
            end
        endcase

        if (apb_wr)
        begin
            if (PADDR == OFS_INSTR)
            begin
                next_r.instr = issue_word;
                if (is_op(issue_word, PAT_WAIT, MSK_WAIT))
                begin
                    next_r.mask = issue_word[FLD_MASK_HI:0];
                    next_r.state = ST_WAIT;
                end
                else if (is_op(issue_word, PAT_BKD_WR, MSK_BKD_WR))
                begin
                    next_r.state = ST_BKD;
                end
                else
                begin
                    // Single-cycle arithmetic retires immediately
                    if (exec_reg_we)
                        next_r.alu[issue_reg] = exec_result;
                    next_r.cs = exec_cs;
                    if (exec_flags_we)
                    begin
                        next_r.zero_flag = exec_zero;
                        next_r.ones_flag = exec_ones;
                    end
                    next_r.pc = PC_W'(r.pc + 1'b1);
                end
            end
            else if (PADDR == OFS_IMM)
                next_r.imm = PWDATA[15:0];
            else if (PADDR == OFS_BKD_ADDR)
                next_r.bkd_addr = PWDATA[BKD_AW-1:0];
            else if (PADDR == OFS_BKD_DATA)
                next_r.bkd_data = PWDATA[15:0];
            else if (is_alu(PADDR))
                next_r.alu[ai] = PWDATA[15:0];
            else if (is_dest(PADDR))
                next_r.dest[di] = PWDATA[PC_W-1:0];
        end

        // Stall is registered so the pin carries no decode glitch
        next_r.stall = (next_r.state == ST_WAIT);
    end

    // State register; everything resets to idle with cleared contents
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            r <= '0;
            r.state <= ST_IDLE;
            r.imm <= WORD_RESET;
            r.cs <= FLAG_RESET;
            r.zero_flag <= FLAG_RESET;
            r.ones_flag <= FLAG_RESET;
            r.stall <= FLAG_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // Outputs come straight from the state record
    // Every pin is a bare flop output; nothing is decoded on the way out
    assign PRDATA = r.prdata;
    assign PREADY = r.pready;
    assign PSLVERR = r.pslverr;
    assign CORE_PROGRAM_COUNTER = r.pc;
    assign CORE_STALL = r.stall;
    assign BKD_WR = r.bkd_wr;
    assign BKD_ADDR = r.bkd_addr_o;
    assign BKD_DATA = r.bkd_data_o;
endmodule
`default_nettype wire

// ===== tb/mct_tail_core_properties.sv
// Checker bound to the tail instruction block's top ports.
// Assumes zero-wait APB and one core clock.
`timescale 1ns/100ps
`default_nettype none
module mct_tail_core_properties
#(
    parameter int PC_W = 10,
    parameter int BKD_AW = 16
)
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [4:0] WAIT_COND,
    input wire logic [PC_W-1:0] CORE_PROGRAM_COUNTER,
    input wire logic CORE_STALL,
    input wire logic BKD_WR,
    input wire logic [BKD_AW-1:0] BKD_ADDR,
    input wire logic [15:0] BKD_DATA
);
    // Accepted instruction word at the completing edge
    wire logic iw = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PADDR == 8'h00;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    property p_bkd_lat; iw && PWDATA[15:0] == 16'h3541 |-> ##2 BKD_WR; endproperty
    a_bkd_lat: assert property (p_bkd_lat) else $error("backdoor strobe late");
    property p_bkd_pulse; BKD_WR |=> !BKD_WR; endproperty
    a_bkd_pulse: assert property (p_bkd_pulse) else $error("strobe too long");
    property p_bkd_hold; !BKD_WR |-> $stable(BKD_ADDR) && $stable(BKD_DATA); endproperty
    a_bkd_hold: assert property (p_bkd_hold) else $error("backdoor bus moved");
    property p_wait_stall; iw && PWDATA[15:5] == 11'h1a8 |=> CORE_STALL; endproperty
    a_wait_stall: assert property (p_wait_stall) else $error("wait did not stall");
    property p_pc_hold; CORE_STALL && WAIT_COND == 5'h00 |=> $stable(CORE_PROGRAM_COUNTER);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("counter moved in stall");
    property p_stall_fall; $fell(CORE_STALL) |-> $past(WAIT_COND) != 5'h00; endproperty
    a_stall_fall: assert property (p_stall_fall) else $error("stall left unprompted");
    property p_pc_step; iw && PWDATA[15:3] == 13'h05da |=>
        CORE_PROGRAM_COUNTER == PC_W'($past(CORE_PROGRAM_COUNTER) + 1); endproperty
    a_pc_step: assert property (p_pc_step) else $error("counter did not step");
    property p_zero_mask; iw && PWDATA[15:0] == 16'h3500 |=> CORE_STALL [*8]; endproperty
    a_zero_mask: assert property (p_zero_mask) else $error("empty mask released");
endmodule
`default_nettype wire

// ===== tb/mct_far_model.sv
// Far side: wait condition source and backdoor register space.
// Assumes conditions change only on the core clock.
`timescale 1ns/100ps
`default_nettype none
module mct_far_model
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic BKD_WR,
    input wire logic [15:0] BKD_ADDR,
    input wire logic [15:0] BKD_DATA,
    input wire logic [4:0] cond_set,
    output logic [4:0] WAIT_COND,
    output logic [15:0] last_addr,
    output logic [15:0] last_data,
    output int wr_count
);
    // Conditions follow the request one edge later; writes land on the strobe only
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            WAIT_COND <= 5'h00;
            last_addr <= 16'h0000;
            last_data <= 16'h0000;
            wr_count <= 0;
        end
        else
        begin
            WAIT_COND <= cond_set;
            if (BKD_WR)
            begin
                last_addr <= BKD_ADDR;
                last_data <= BKD_DATA;
                wr_count <= wr_count + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/mct_tail_core_tb.sv
// Bench for the tail instruction block: APB master, far model, checker.
// Assumes zero-wait APB and the package's opcodes and offsets.
`timescale 1ns/100ps
`default_nettype none
module mct_tail_core_tb
    import mct_pkg::*;
;
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [4:0] cond_set = 5'h00;
    logic [31:0] PRDATA, rd;
    logic PREADY, PSLVERR, CORE_STALL, BKD_WR, err;
    logic [4:0] WAIT_COND;
    logic [9:0] CORE_PROGRAM_COUNTER, p;
    logic [15:0] BKD_ADDR, BKD_DATA, last_addr, last_data;
    int wr_count, n, low;
    int err_total = 0;
    int tests_run = 0;
    mct_tail_core u_mct_tail_core (.SYS_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PRDATA, .PREADY, .PSLVERR, .WAIT_COND, .CORE_PROGRAM_COUNTER,
        .CORE_STALL, .BKD_WR, .BKD_ADDR, .BKD_DATA);
    mct_far_model u_mct_far_model (.SYS_CLK, .RST_N, .BKD_WR, .BKD_ADDR, .BKD_DATA,
        .cond_set, .WAIT_COND, .last_addr, .last_data, .wr_count);
    always #12.5 SYS_CLK = ~SYS_CLK;
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Request held from setup until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do @(posedge SYS_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask
    task automatic do_reset;
        RST_N <= 1'b0;
        repeat (16) @(posedge SYS_CLK);
        RST_N <= 1'b1;
    endtask
    task automatic t_regs;
        rdchk("status", OFS_STATUS, 32'h0);
        rdchk("imm", OFS_IMM, 32'h0);
        apb(1'b0, 8'h80, 32'h0);
        check("unmapped err", err, 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, OFS_STATUS, 32'hffff_ffff);
        check("status wr err", err, 32'h0);
        apb(1'b1, OFS_INSTR, 32'h0000_ffff);
        check("illegal err", err, 32'h1);
        rdchk("illegal kept", OFS_STATUS, 32'h0);
        $display("t_regs done");
    endtask
    task automatic t_conv;
        apb(1'b1, 8'h28, 32'h8005);
        apb(1'b1, OFS_INSTR, 32'h372a);
        rdchk("neg", 8'h28, 32'h7ffb);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("cs set", rd[0], 32'h1);
        apb(1'b1, OFS_INSTR, 32'h3732);
        rdchk("back", 8'h28, 32'h8005);
        apb(1'b1, 8'h2c, 32'h1234);
        apb(1'b1, OFS_INSTR, 32'h3723);
        rdchk("pos", 8'h2c, 32'h1234);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("cs xor0", rd[0], 32'h1);
        apb(1'b1, 8'h2c, 32'h8001);
        apb(1'b1, OFS_INSTR, 32'h3723);
        rdchk("neg2", 8'h2c, 32'h7fff);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("cs xor1", rd[0], 32'h0);
        apb(1'b1, 8'h2c, 32'h8001);
        apb(1'b1, OFS_INSTR, 32'h3733);
        rdchk("fwd0", 8'h2c, 32'h0001);
        $display("t_conv done");
    endtask
    task automatic t_xor;
        apb(1'b1, OFS_IMM, 32'h00ff);
        apb(1'b1, 8'h3c, 32'h00ff);
        @(negedge SYS_CLK);
        p = CORE_PROGRAM_COUNTER;
        apb(1'b1, OFS_INSTR, 32'h2ed7);
        @(negedge SYS_CLK);
        check("pc", CORE_PROGRAM_COUNTER, 32'(p + 10'h001));
        rdchk("xor0", 8'h3c, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("zero", rd[2:1], 32'h1);
        apb(1'b1, OFS_IMM, 32'hffff);
        apb(1'b1, OFS_INSTR, 32'h2ed7);
        rdchk("xor1", 8'h3c, 32'hffff);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("ones", rd[2:1], 32'h2);
        $display("t_xor done");
    endtask
    task automatic t_bkd;
        apb(1'b1, OFS_BKD_ADDR, 32'h1234);
        apb(1'b1, OFS_BKD_DATA, 32'habcd);
        n = wr_count;
        apb(1'b1, OFS_INSTR, 32'h3541);
        repeat (4) @(posedge SYS_CLK);
        check("bkd count", wr_count, n + 1);
        check("bkd addr", last_addr, 32'h1234);
        check("bkd data", last_data, 32'habcd);
        $display("t_bkd done");
    endtask
    task automatic t_wait;
        for (int i = 0; i < 5; i++)
            apb(1'b1, OFS_DEST_BASE + 8'(4 * i), 32'h100 + i);
        for (int m = 1; m < 32; m++)
        begin
            low = 0;
            while (!m[low])
                low++;
            cond_set <= 5'(~m);
            apb(1'b1, OFS_INSTR, 32'h3500 | m);
            repeat (3) @(posedge SYS_CLK);
            p = CORE_PROGRAM_COUNTER;
            apb(1'b1, OFS_INSTR, 32'h2ed0);
            check("busy err", err, 32'h1);
            check("stall pc", CORE_PROGRAM_COUNTER, p);
            cond_set <= 5'(m);
            for (int k = 0; k < 20 && CORE_STALL; k++)
                @(posedge SYS_CLK);
            @(negedge SYS_CLK);
            check("stall", CORE_STALL, 32'h0);
            check("dest", CORE_PROGRAM_COUNTER, 32'h100 + low);
            cond_set <= 5'h00;
        end
        $display("t_wait done");
    endtask
    task automatic t_mask0;
        cond_set <= 5'h1f;
        apb(1'b1, OFS_INSTR, 32'h3500);
        @(negedge SYS_CLK);
        p = CORE_PROGRAM_COUNTER;
        repeat (40) @(posedge SYS_CLK);
        apb(1'b1, OFS_INSTR, 32'h2ed0);
        check("mask0 err", err, 32'h1);
        check("mask0 stall", CORE_STALL, 32'h1);
        check("mask0 pc", CORE_PROGRAM_COUNTER, p);
        cond_set <= 5'h00;
        do_reset;
        @(negedge SYS_CLK);
        check("rst stall", CORE_STALL, 32'h0);
        check("rst pc", CORE_PROGRAM_COUNTER, 32'h0);
        $display("t_mask0 done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        do_reset;
        t_regs;
        t_conv;
        t_xor;
        t_bkd;
        t_wait;
        t_mask0;
        end_of_test;
    end
    // Far above the few hundred cycles the tests need
    initial
    begin
        #(25 * 20000);
        err_total++;
        end_of_test;
    end
endmodule
bind mct_tail_core mct_tail_core_properties #(.PC_W(PC_W), .BKD_AW(BKD_AW))
    u_mct_tail_core_properties (.SYS_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .WAIT_COND, .CORE_PROGRAM_COUNTER,
    .CORE_STALL, .BKD_WR, .BKD_ADDR, .BKD_DATA);
`default_nettype wire
